// [common/iwcs_pkg.sv]
// Constants and carrier types for the wiper code serial slave.
// Assumes the link side runs from an oversampling clock far faster than the serial clock.
package iwcs_pkg;

    localparam int        ADDR_W        = 7;
    localparam int        BYTE_W        = 8;
    localparam int        CODE_W        = 7;
    localparam int        CNT_W         = 4;

    // Own address of the first variant; the other variant differs only in one bit.
    localparam logic [6:0] ADDR_VARIANT_A = 7'h2E;
    localparam int         ADDR_ALT_BIT   = 5;
    localparam logic [6:0] ADDR_GEN_CALL  = 7'h00;

    // Byte layout: direction flag in bit 0, address in bits 7 to 1.
    localparam int         RW_BIT         = 0;
    localparam int         ADDR_MSB       = 7;
    localparam int         ADDR_LSB       = 1;
    localparam int         CODE_MSB       = 6;

    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
    localparam logic [3:0] CNT_ZERO       = 4'h0;
    localparam logic [3:0] CNT_ONE        = 4'h1;

    // Midscale code, where both halves of the resistor are equal.
    localparam logic [6:0] WIPER_RESET    = 7'h40;

    typedef struct packed {
        logic scl;
        logic sda;
    } iwcs_pins_s;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_ADDR     = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_WR_DATA  = 3'b011,
        ST_WR_ACK   = 3'b100,
        ST_RD_DATA  = 3'b101,
        ST_RD_ACK   = 3'b110,
        ST_IGNORE   = 3'b111
    } iwcs_state_e;

endpackage

// [hw/iwcs_sync.sv]
// Two flip-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a level that stays put for several destination clocks.
`timescale 1ns/1ps
module iwcs_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // No reset here, so the chain also serves to carry a reset across.
    always_ff @(posedge i_clk)
    begin
        meta_q <= i_async;
        sync_q <= meta_q;
    end

    assign o_sync = sync_q;

endmodule

// [hw/iwcs_xfer.sv]
// Toggle request and acknowledge handshake that carries one word between clocks.
// Assumes both resets are synchronous to their own clocks and overlap in time.
`timescale 1ns/1ps
module iwcs_xfer #(
    parameter int           W        = 7,
    parameter logic [W-1:0] RST_DATA = '0
) (
    input  wire logic         i_src_clk,
    input  wire logic         i_src_rst,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_data,
    input  wire logic         i_dst_clk,
    input  wire logic         i_dst_rst,
    output logic              o_strobe,
    output logic      [W-1:0] o_data
);

    logic         req_q;
    logic         ack_s;
    logic         busy;
    logic         pend_q;
    logic [W-1:0] pend_data_q;
    logic [W-1:0] data_q;
    logic         req_s;
    logic         seen_q;
    logic         strobe_q;
    logic [W-1:0] out_q;

    assign busy = (req_q != ack_s);

    // The word is held still until the far side has answered, so it may be sampled whole.
    always_ff @(posedge i_src_clk)
    begin
        if (i_src_rst)
        begin
            req_q  <= 1'b0;
            data_q <= RST_DATA;
        end
        else if (!busy && (i_load || pend_q))
        begin
            data_q <= i_load ? i_data : pend_data_q;
            req_q  <= ~req_q;
        end
    end

    // A word that arrives while busy is parked; only the latest one is kept.
    always_ff @(posedge i_src_clk)
    begin
        if (i_src_rst)
        begin
            pend_q      <= 1'b0;
            pend_data_q <= RST_DATA;
        end
        else if (busy)
        begin
            if (i_load)
            begin
                pend_q      <= 1'b1;
                pend_data_q <= i_data;
            end
        end
        else
        begin
            pend_q <= 1'b0;
        end
    end

    iwcs_sync #(.W(1)) u_req_sync (
        .i_clk   (i_dst_clk),
        .i_async (req_q),
        .o_sync  (req_s)
    );

    iwcs_sync #(.W(1)) u_ack_sync (
        .i_clk   (i_src_clk),
        .i_async (seen_q),
        .o_sync  (ack_s)
    );

    always_ff @(posedge i_dst_clk)
    begin
        if (i_dst_rst)
        begin
            seen_q   <= 1'b0;
            strobe_q <= 1'b0;
            out_q    <= RST_DATA;
        end
        else
        begin
            strobe_q <= (req_s != seen_q);
            if (req_s != seen_q)
            begin
                seen_q <= req_s;
                out_q  <= data_q;
            end
        end
    end

    assign o_strobe = strobe_q;
    assign o_data   = out_q;

endmodule

// [hw/iwcs_top.sv]
// Serial slave that receives and returns the 7-bit wiper position code.
// Assumes open-drain pins resolved outside, and a link clock far faster than the bus clock.
`timescale 1ns/1ps
module iwcs_top
    import iwcs_pkg::*;
#(
    parameter bit VARIANT_ALT = 1'b0
) (
    input  wire logic              I_CORE_CLK,
    input  wire logic              I_RESET,
    input  wire logic              I_LINK_CLK,
    input  wire logic              I_SCL,
    input  wire logic              I_SDA_I,
    output logic                   O_SDA_O,
    output logic                   O_SDA_OE,
    output logic      [CODE_W-1:0] O_WIPER_CODE,
    output logic                   O_WIPER_STB
);

    // own address
    // The alternative bit is counted in byte positions, so it moves down past the flag bit.
    localparam logic [ADDR_W-1:0] OWN_ADDR =
        VARIANT_ALT ? (ADDR_VARIANT_A | (7'h01 << (ADDR_ALT_BIT - ADDR_LSB)))
                    : ADDR_VARIANT_A;

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain: pin sampling and conditions.

    logic              link_rst;
    iwcs_pins_s        pins_raw;
    iwcs_pins_s        pins_s;
    iwcs_pins_s        pins_p_q;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_det;
    logic              stop_det;

    iwcs_state_e       state_q;
    logic [CNT_W-1:0]  cnt_q;
    logic [BYTE_W-1:0] rx_q;
    logic [BYTE_W-1:0] tx_q;
    logic              rw_q;
    logic              sda_oe_q;
    logic              sda_o_q;
    logic              commit_q;
    logic [CODE_W-1:0] code_q;
    logic              byte_done;

    iwcs_sync #(.W(1)) u_rst_sync (
        .i_clk   (I_LINK_CLK),
        .i_async (I_RESET),
        .o_sync  (link_rst)
    );

    assign pins_raw.scl = I_SCL;
    assign pins_raw.sda = I_SDA_I;

    iwcs_sync #(.W(2)) u_pin_sync (
        .i_clk   (I_LINK_CLK),
        .i_async (pins_raw),
        .o_sync  (pins_s)
    );

    // Idle bus levels are high, so no false edge is seen as reset lifts.
    always_ff @(posedge I_LINK_CLK)
    begin
        if (link_rst)
            pins_p_q <= '{scl: 1'b1, sda: 1'b1};
        else
            pins_p_q <= pins_s;
    end

    assign scl_rise  = pins_s.scl & ~pins_p_q.scl;
    assign scl_fall  = ~pins_s.scl & pins_p_q.scl;
    assign start_det = pins_s.scl & pins_p_q.scl & pins_p_q.sda & ~pins_s.sda;
    assign stop_det  = pins_s.scl & pins_p_q.scl & ~pins_p_q.sda & pins_s.sda;
    assign byte_done = (cnt_q == BITS_PER_BYTE);

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain: protocol sequencer.

    always_ff @(posedge I_LINK_CLK)
    begin
        if (link_rst)
            state_q <= ST_IDLE;
        else if (start_det)
            state_q <= ST_ADDR;
        else if (stop_det)
            state_q <= ST_IDLE;
        else if (scl_fall)
        begin
            case (state_q)
                ST_ADDR:
                begin
                    if (byte_done && rx_q[ADDR_MSB:ADDR_LSB] == OWN_ADDR)
                        state_q <= ST_ADDR_ACK;
                    else if (byte_done)
                        state_q <= ST_IGNORE;
                end
                ST_ADDR_ACK:
                    state_q <= rw_q ? ST_RD_DATA : ST_WR_DATA;
                ST_WR_DATA:
                    if (byte_done)
                        state_q <= ST_WR_ACK;
                ST_WR_ACK:
                    state_q <= ST_WR_DATA;
                ST_RD_DATA:
                    if (byte_done)
                        state_q <= ST_RD_ACK;
                // A refused byte ends the read; the slave waits for stop or start.
                ST_RD_ACK:
                    state_q <= rx_q[0] ? ST_IGNORE : ST_RD_DATA;
                default:
                    state_q <= state_q;
            endcase
        end
    end

    always_ff @(posedge I_LINK_CLK)
    begin
        if (link_rst || start_det || stop_det)
            cnt_q <= CNT_ZERO;
        else if (scl_rise && (state_q == ST_ADDR || state_q == ST_WR_DATA
                              || state_q == ST_RD_DATA))
            cnt_q <= cnt_q + CNT_ONE;
        else if (scl_fall && (state_q == ST_ADDR_ACK || state_q == ST_WR_ACK
                              || state_q == ST_RD_ACK))
            cnt_q <= CNT_ZERO;
    end

    always_ff @(posedge I_LINK_CLK)
    begin
        if (link_rst)
        begin
            rx_q <= '0;
            rw_q <= 1'b0;
        end
        else if (scl_rise)
        begin
            rx_q <= {rx_q[BYTE_W-2:0], pins_s.sda};
            if (state_q == ST_ADDR && cnt_q == (BITS_PER_BYTE - CNT_ONE))
                rw_q <= pins_s.sda;
        end
    end

    // The wire level is always low; only the enable moves, as open drain requires.
    always_ff @(posedge I_LINK_CLK)
    begin
        sda_o_q <= 1'b0;
    end

    // Pin drive changes on a falling clock, apart from release at start, stop or reset, so data is steady while the clock is high.
    always_ff @(posedge I_LINK_CLK)
    begin
        if (link_rst || start_det || stop_det)
        begin
            sda_oe_q <= 1'b0;
            tx_q     <= '0;
        end
        else if (scl_fall)
        begin
            case (state_q)
                ST_ADDR:
                    sda_oe_q <= byte_done && (rx_q[ADDR_MSB:ADDR_LSB] == OWN_ADDR)
                                && (rx_q[ADDR_MSB:ADDR_LSB] != ADDR_GEN_CALL);
                ST_ADDR_ACK, ST_RD_ACK:
                begin
                    tx_q     <= {1'b0, code_q};
                    sda_oe_q <= (rw_q && !(state_q == ST_RD_ACK && rx_q[0]));
                end
                ST_WR_DATA:
                    sda_oe_q <= byte_done;
                ST_RD_DATA:
                begin
                    if (byte_done)
                        sda_oe_q <= 1'b0;
                    else
                    begin
                        tx_q     <= {tx_q[BYTE_W-2:0], 1'b0};
                        sda_oe_q <= ~tx_q[BYTE_W-2];
                    end
                end
                default:
                    sda_oe_q <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge I_LINK_CLK)
    begin
        if (link_rst)
        begin
            commit_q <= 1'b0;
            code_q   <= WIPER_RESET;
        end
        else
        begin
            commit_q <= scl_rise && (state_q == ST_WR_ACK) && !start_det && !stop_det;
            if (scl_rise && (state_q == ST_WR_ACK))
                code_q <= rx_q[CODE_MSB:0];
        end
    end

    assign O_SDA_OE = sda_oe_q;
    assign O_SDA_O  = sda_o_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Core domain: code register fed through the handshake.

    logic              xfer_stb;
    logic [CODE_W-1:0] xfer_data;
    logic [CODE_W-1:0] wiper_q;
    logic              wiper_stb_q;

    iwcs_xfer #(.W(CODE_W), .RST_DATA(WIPER_RESET)) u_xfer (
        .i_src_clk (I_LINK_CLK),
        .i_src_rst (link_rst),
        .i_load    (commit_q),
        .i_data    (code_q),
        .i_dst_clk (I_CORE_CLK),
        .i_dst_rst (I_RESET),
        .o_strobe  (xfer_stb),
        .o_data    (xfer_data)
    );

    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RESET)
        begin
            wiper_q     <= WIPER_RESET;
            wiper_stb_q <= 1'b0;
        end
        else
        begin
            wiper_stb_q <= xfer_stb;
            if (xfer_stb)
                wiper_q <= xfer_data;
        end
    end

    assign O_WIPER_CODE = wiper_q;
    assign O_WIPER_STB  = wiper_stb_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    a_start_to_addr: assert property (
        @(posedge I_LINK_CLK) disable iff (link_rst)
        start_det |=> (state_q == ST_ADDR) && !sda_oe_q && (cnt_q == CNT_ZERO))
        else $error("start did not open an address phase");

    a_stop_to_idle: assert property (
        @(posedge I_LINK_CLK) disable iff (link_rst)
        (stop_det && !start_det) |=> (state_q == ST_IDLE) && !sda_oe_q)
        else $error("stop did not return to idle");

    a_gen_call_quiet: assert property (
        @(posedge I_LINK_CLK) disable iff (link_rst)
        (state_q == ST_ADDR && scl_fall && byte_done && !start_det && !stop_det
         && rx_q[ADDR_MSB:ADDR_LSB] == ADDR_GEN_CALL)
        |=> !sda_oe_q && (state_q == ST_IGNORE))
        else $error("general call was answered");

    a_addr_ack_drive: assert property (
        @(posedge I_LINK_CLK) disable iff (link_rst)
        (state_q == ST_ADDR && scl_fall && byte_done && !start_det && !stop_det
         && rx_q[ADDR_MSB:ADDR_LSB] == OWN_ADDR)
        |=> sda_oe_q && (state_q == ST_ADDR_ACK))
        else $error("own address not acknowledged");

    a_ack_in_high: assert property (
        @(posedge I_LINK_CLK) disable iff (link_rst)
        ((state_q == ST_WR_ACK || state_q == ST_ADDR_ACK) && scl_rise) |-> sda_oe_q)
        else $error("acknowledge not held through clock high");

    a_release_wr: assert property (
        @(posedge I_LINK_CLK) disable iff (link_rst)
        (state_q == ST_WR_DATA || state_q == ST_ADDR || state_q == ST_RD_ACK
         || state_q == ST_IDLE) |-> !sda_oe_q)
        else $error("data line driven in a master slot");

    a_bit_step: assert property (
        @(posedge I_LINK_CLK) disable iff (link_rst)
        (scl_rise && state_q == ST_WR_DATA && !start_det && !stop_det)
        |=> cnt_q == $past(cnt_q) + CNT_ONE)
        else $error("bit counter did not step on a clock pulse");

    a_commit_whole: assert property (
        @(posedge I_LINK_CLK) disable iff (link_rst)
        commit_q |-> ($past(state_q) == ST_WR_ACK) && ($past(cnt_q) == BITS_PER_BYTE))
        else $error("code taken from a partial byte");

    a_code_low_bits: assert property (
        @(posedge I_LINK_CLK) disable iff (link_rst)
        commit_q |-> code_q == $past(rx_q[CODE_MSB:0]))
        else $error("code does not hold the low seven bits");

    a_read_msb_zero: assert property (
        @(posedge I_LINK_CLK) disable iff (link_rst)
        (state_q == ST_ADDR_ACK && scl_fall && rw_q && !start_det && !stop_det)
        |=> sda_oe_q && tx_q == {1'b0, $past(code_q)})
        else $error("read did not start with a zero top bit");

    a_core_update: assert property (
        @(posedge I_CORE_CLK) disable iff (I_RESET)
        xfer_stb |=> O_WIPER_STB && (O_WIPER_CODE == $past(xfer_data)))
        else $error("core wiper code not updated");

    c_write_commit: cover property (
        @(posedge I_LINK_CLK) disable iff (link_rst) commit_q);
    c_read_entry: cover property (
        @(posedge I_LINK_CLK) disable iff (link_rst) state_q == ST_RD_DATA);
    c_gen_call: cover property (
        @(posedge I_LINK_CLK) disable iff (link_rst)
        state_q == ST_ADDR && scl_fall && byte_done && rx_q[ADDR_MSB:ADDR_LSB] == ADDR_GEN_CALL);
    c_core_strobe: cover property (
        @(posedge I_CORE_CLK) disable iff (I_RESET) O_WIPER_STB);

endmodule

// [tb/iwcs_master_model.sv]
// Behavioural bus master that runs start, stop and byte transfers on the serial pins.
// Assumes a pull-up on the data wire, resolved by the bench from all three pull-down enables.
`timescale 1ns/1ps
module iwcs_master_model (
    output logic       o_scl,
    output logic       o_sda_oe,
    input  wire logic  i_sda,
    output int         o_bit_err
);
    // Each clock phase lasts one or two quarters (one only before a repeated start), so at least six link clocks.
    localparam int QTR_NS = 400;

    initial
    begin
        o_scl     = 1'b1;
        o_sda_oe  = 1'b0;
        o_bit_err = 0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // the bench starts on an idle bus or as a repeated start; data falls while clock is high.
    task automatic start_cond();
        o_sda_oe = 1'b0;
        #QTR_NS o_scl = 1'b1;
        #QTR_NS o_sda_oe = 1'b1;
        #QTR_NS o_scl = 1'b0;
    endtask

    // data rises while the clock is high.
    task automatic stop_cond();
        #QTR_NS o_sda_oe = 1'b1;
        #QTR_NS o_scl = 1'b1;
        #QTR_NS o_sda_oe = 1'b0;
        #(4 * QTR_NS);
    endtask

    // one bit a pulse, data moved only while the clock is low.
    task automatic bit_slot(input logic b, output logic seen);
        #QTR_NS o_sda_oe = ~b;
        #QTR_NS o_scl = 1'b1;
        #QTR_NS seen = i_sda;
        #QTR_NS o_scl = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // msb first, n bits, then data let go for the acknowledge when n is eight.
    task automatic send_byte(input logic [7:0] b, input int n, output logic ack);
        logic s;
        ack = 1'b0;
        for (int i = 7; i > 7 - n; i--)
        begin
            bit_slot(b[i], s);
            if (s !== b[i])
                o_bit_err++;
        end
        if (n == 8)
        begin
            bit_slot(1'b1, s);
            ack = (s === 1'b0);
        end
    endtask

    // the master releases data while the slave sends, then answers.
    task automatic recv_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_slot(1'b1, b[i]);
        bit_slot(~ack, s);
    endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for the wiper code serial slave.
// Assumes the master model owns the bus pins and the data wire has a pull-up.
`timescale 1ns/1ps
module testbench
    import iwcs_pkg::*;
;
    logic              core_clk;
    logic              link_clk;
    logic              rst;
    logic              scl;
    logic              m_oe;
    logic              sda_o;
    logic              sda_oe;
    logic              stb;
    logic [CODE_W-1:0] code;
    logic              sda_o_b;
    logic              sda_oe_b;
    logic [CODE_W-1:0] code_b;
    wire logic         sda;
    int                bit_err;
    int                bad_count;
    int                comparisons;
    int                stb_count;
    logic              aa;
    logic              da;
    logic [7:0]        rd;

    // Wired-and of the master and both slaves, with the pull-up as the idle level.
    assign sda = !(m_oe || (sda_oe && !sda_o) || (sda_oe_b && !sda_o_b));

    iwcs_top #(.VARIANT_ALT(1'b0)) u_iwcs_top (
        .I_CORE_CLK   (core_clk),
        .I_RESET      (rst),
        .I_LINK_CLK   (link_clk),
        .I_SCL        (scl),
        .I_SDA_I      (sda),
        .O_SDA_O      (sda_o),
        .O_SDA_OE     (sda_oe),
        .O_WIPER_CODE (code),
        .O_WIPER_STB  (stb)
    );

    // The alternative variant shares the bus, so every address reaches both slaves.
    iwcs_top #(.VARIANT_ALT(1'b1)) u_iwcs_top_alt (
        .I_CORE_CLK   (core_clk),
        .I_RESET      (rst),
        .I_LINK_CLK   (link_clk),
        .I_SCL        (scl),
        .I_SDA_I      (sda),
        .O_SDA_O      (sda_o_b),
        .O_SDA_OE     (sda_oe_b),
        .O_WIPER_CODE (code_b),
        .O_WIPER_STB  ()
    );

    iwcs_master_model u_iwcs_master_model (
        .o_scl     (scl),
        .o_sda_oe  (m_oe),
        .i_sda     (sda),
        .o_bit_err (bit_err)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // The link clock starts off phase so that its edges never line up with the core.
    initial
    begin
        link_clk = 1'b0;
        #5;
        forever #32 link_clk = ~link_clk;
    end

    // The strobe is launched on the rising edge, so it is counted where it has settled.
    always @(negedge core_clk)
        if (stb === 1'b1)
            stb_count++;

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        if (bad_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr_tx(input logic [6:0] a, input logic [7:0] d);
        u_iwcs_master_model.start_cond();
        u_iwcs_master_model.send_byte({a, 1'b0}, 8, aa);
        u_iwcs_master_model.send_byte(d, 8, da);
        u_iwcs_master_model.stop_cond();
        repeat (64) @(posedge core_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check("code", {1'b0, code}, 8'h40);
        check("oe", {7'h00, sda_oe}, 8'h00);
        check("sda_o", {7'h00, sda_o}, 8'h00);
    endtask

    task automatic t_write();
        int s0;
        s0 = stb_count;
        wr_tx(ADDR_VARIANT_A, 8'hD5);
        check("addr ack", {7'h00, aa}, 8'h01);
        check("data ack", {7'h00, da}, 8'h01);
        check("code", {1'b0, code}, 8'h55);
        check("strobes", 8'(stb_count - s0), 8'h01);
    endtask

    task automatic t_refused(input logic [6:0] a);
        int s0;
        s0 = stb_count;
        wr_tx(a, 8'h11);
        check("no ack", {7'h00, aa}, 8'h00);
        check("code kept", {1'b0, code}, 8'h55);
        check("no strobe", 8'(stb_count - s0), 8'h00);
        check("alt code kept", {1'b0, code_b}, 8'h40);
    endtask

    task automatic t_alt();
        int s0;
        s0 = stb_count;
        wr_tx(ADDR_VARIANT_A | 7'h10, 8'h9A);
        check("alt ack", {7'h00, aa}, 8'h01);
        check("alt code", {1'b0, code_b}, 8'h1A);
        check("main code kept", {1'b0, code}, 8'h55);
        check("main no strobe", 8'(stb_count - s0), 8'h00);
    endtask

    task automatic t_multi_partial();
        int s0;
        s0 = stb_count;
        u_iwcs_master_model.start_cond();
        u_iwcs_master_model.send_byte({ADDR_VARIANT_A, 1'b0}, 8, aa);
        u_iwcs_master_model.send_byte(8'h01, 8, da);
        u_iwcs_master_model.send_byte(8'h7F, 8, da);
        u_iwcs_master_model.send_byte(8'hA5, 4, da);
        u_iwcs_master_model.stop_cond();
        repeat (64) @(posedge core_clk);
        check("last code", {1'b0, code}, 8'h7F);
        check("two strobes", 8'(stb_count - s0), 8'h02);
    endtask

    task automatic t_read();
        u_iwcs_master_model.start_cond();
        u_iwcs_master_model.send_byte({ADDR_VARIANT_A, 1'b0}, 8, aa);
        u_iwcs_master_model.start_cond();
        u_iwcs_master_model.send_byte({ADDR_VARIANT_A, 1'b1}, 8, aa);
        check("read ack", {7'h00, aa}, 8'h01);
        u_iwcs_master_model.recv_byte(1'b1, rd);
        check("read 1", rd, 8'h7F);
        u_iwcs_master_model.recv_byte(1'b0, rd);
        check("read 2", rd, 8'h7F);
        u_iwcs_master_model.stop_cond();
        check("bit errors", 8'(bit_err), 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst = 1'b1;
        bad_count = 0;
        comparisons = 0;
        stb_count = 0;
        // The link reset needs its own chain, so reset spans eight link clocks.
        repeat (8) @(posedge link_clk);
        @(posedge core_clk);
        #1 rst = 1'b0;
        #1000;
        t_reset();
        t_write();
        t_refused(ADDR_GEN_CALL);
        t_alt();
        t_multi_partial();
        t_read();
        final_report();
    end

    initial
    begin
        #700_000;
        bad_count++;
        final_report();
    end
endmodule
